// ---- core/usbif_dwell.sv ----
`timescale 1ns/100ps
// ==========================================================
// pulses once when cond has held for CYCLES clocks in a row
module usbif_dwell #(
    parameter int unsigned CYCLES = 313,
    parameter int W = $clog2(CYCLES + 1)
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic cond,
    output logic hit
);
    localparam logic [W-1:0] LIMIT = W'(CYCLES);
    logic [W-1:0] cnt_reg;
    logic hit_reg;
    wire last = cond && (cnt_reg == LIMIT - 1'b1);
    // saturating run counter, cleared when cond drops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= '0;
            hit_reg <= 1'b0;
        end else begin
            hit_reg <= last;
            if (!cond) begin
                cnt_reg <= '0;
            end else if (cnt_reg != LIMIT) begin
                cnt_reg <= cnt_reg + 1'b1;
            end
        end
    end
    assign hit = hit_reg;
endmodule

// ---- core/usbif_flags.sv ----
// Functional notes
// R1: hardware sets flags, writing one clears
// R2: bits 31 to 8 read zero
// R3: host mode: received stall sets bit 7
// R4: device mode: transmitted stall sets bit 7
// R5: attach detection sets bit 6
// R6: attach needs host, 2.5 us quiet, no se0
// R7: k state for 2.5 us sets bit 5
// R8: software disables resume interrupt outside suspend
// R9: idle for 3 ms sets bit 4
// R10: token finished sets bit 3
// R11: clearing token flag advances status fifo
// R12: sof received or host threshold sets bit 2
// R13: only enabled errors set bit 1
// R14: device mode: bus reset sets bit 0
// R15: host mode: detach sets bit 0
// R16: error summary read-only, follows enabled errors
// R17: zero writes ignored, set beats clear
//
`timescale 1ns/100ps
`include "usbif_regs.svh"
module usbif_flags
    import usbif_pkg::*;
#(
    parameter int unsigned QUIET_CYCLES = `USBIF_CYC_QUIET,
    parameter int unsigned IDLE_CYCLES = `USBIF_CYC_IDLE,
    parameter int ERR_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic dp_pin,
    input wire logic dm_pin,
    input wire logic stall_rx,
    input wire logic stall_tx,
    input wire logic token_done,
    input wire logic sof_rx,
    input wire logic sof_threshold,
    input wire logic [ERR_W-1:0] error_flags,
    output logic host_mode_enable,
    output logic fifo_advance,
    output logic irq
);
    // ==========================================================
    // state
    usbif_flags_t flags_reg;
    usbif_flags_t flags_next;
    usbif_flags_t irq_en_reg;
    logic [ERR_W-1:0] err_en_reg;
    logic host_reg;
    logic err_sum_reg;
    logic fifo_adv_reg;
    logic irq_reg;
    logic [31:0] prdata_reg;
    usbif_att_state_t att_reg;
    usbif_att_state_t att_next;

    // ==========================================================
    // line state from the pins
    usbif_line_if line ();

    // three-flop synchroniser and level filter for the data lines
    usbif_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .dp_pin(dp_pin),
        .dm_pin(dm_pin),
        .line(line)
    );

    // ==========================================================
    // line dwell detectors
    logic resume_hit;
    logic idle_hit;
    logic attach_hit;
    logic detach_hit;
    logic bus_rst_hit;

    // quiet non-se0 bus while host and no peripheral seen
    wire attach_cond = host_reg && (att_reg == att_detached)
        && !line.se0 && !line.changed; // R6
    // se0 while host and peripheral present
    wire detach_cond = host_reg && (att_reg == att_attached) && line.se0;
    // se0 held in device mode
    wire bus_rst_cond = !host_reg && line.se0;

    // resume: k state held for the quiet time
    usbif_dwell #(.CYCLES(QUIET_CYCLES)) u_resume (
        .pclk(pclk),
        .presetn(presetn),
        .cond(line.k_state),
        .hit(resume_hit)
    );

    // idle: j state held for the idle time
    usbif_dwell #(.CYCLES(IDLE_CYCLES)) u_idle (
        .pclk(pclk),
        .presetn(presetn),
        .cond(line.j_state),
        .hit(idle_hit)
    );

    // attach: quiet non-se0 bus in host mode
    usbif_dwell #(.CYCLES(QUIET_CYCLES)) u_attach (
        .pclk(pclk),
        .presetn(presetn),
        .cond(attach_cond),
        .hit(attach_hit)
    );

    // detach: se0 held with a peripheral present
    usbif_dwell #(.CYCLES(QUIET_CYCLES)) u_detach (
        .pclk(pclk),
        .presetn(presetn),
        .cond(detach_cond),
        .hit(detach_hit)
    );

    // bus reset: se0 held in device mode
    usbif_dwell #(.CYCLES(QUIET_CYCLES)) u_bus_rst (
        .pclk(pclk),
        .presetn(presetn),
        .cond(bus_rst_cond),
        .hit(bus_rst_hit)
    );

    // ==========================================================
    // attach tracking in host mode
    always_comb begin
        att_next = att_reg;
        case (att_reg)
            att_detached: begin
                if (attach_hit && host_reg) begin
                    att_next = att_attached;
                end
            end
            att_attached: begin
                if (detach_hit || !host_reg) begin
                    att_next = att_detached;
                end
            end
            default: begin
                att_next = att_detached;
            end
        endcase
    end

    // attach state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            att_reg <= att_detached;
        end else begin
            att_reg <= att_next;
        end
    end

    // ==========================================================
    // helpers
    // a register is hit only by its exact word address
    function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] off);
        return addr == off;
    endfunction

    // host mode takes the host meaning of a shared event source
    function automatic logic by_mode(input logic host, input logic h_evt, input logic d_evt);
        return host ? h_evt : d_evt;
    endfunction

    // ==========================================================
    // apb decode
    wire setup = psel && !penable;
    wire access = psel && penable;
    wire wr_take = access && pwrite;
    wire lane0 = pstrb[0];
    wire sel_flags = addr_hit(paddr, `USBIF_OFF_FLAGS);
    wire sel_irq_en = addr_hit(paddr, `USBIF_OFF_IRQ_EN);
    wire sel_clear = addr_hit(paddr, `USBIF_OFF_CLEAR);
    wire sel_err_en = addr_hit(paddr, `USBIF_OFF_ERR_EN);
    wire sel_ctrl = addr_hit(paddr, `USBIF_OFF_CTRL);
    wire sel_line = addr_hit(paddr, `USBIF_OFF_LINE);
    wire mapped = sel_flags || sel_irq_en || sel_clear
        || sel_err_en || sel_ctrl || sel_line;
    wire wr_ok = wr_take && mapped && lane0;

    // ==========================================================
    // flag set sources, host and device meanings selected by mode
    usbif_flags_t set_vec;
    usbif_flags_t clr_vec;
    wire stall_evt = by_mode(host_reg, stall_rx, stall_tx); // R3 R4
    wire sof_evt = by_mode(host_reg, sof_threshold, sof_rx); // R12
    wire bit0_evt = by_mode(host_reg, detach_hit, bus_rst_hit); // R14 R15
    wire attach_evt = attach_hit && host_reg; // R5 R6

    always_comb begin
        set_vec = '0;
        set_vec[`USBIF_BIT_STALL] = stall_evt;
        set_vec[`USBIF_BIT_ATTACH] = attach_evt;
        set_vec[`USBIF_BIT_RESUME] = resume_hit; // R7
        set_vec[`USBIF_BIT_IDLE] = idle_hit; // R9
        set_vec[`USBIF_BIT_TOKEN] = token_done; // R10
        set_vec[`USBIF_BIT_SOF] = sof_evt;
        set_vec[`USBIF_BIT_RST_DET] = bit0_evt;
    end

    // ones written to flags or clear register clear every bit but bit 1, zeros do nothing
    wire clr_sel = wr_ok && (sel_flags || sel_clear);
    assign clr_vec = clr_sel ? (pwdata[7:0] & `USBIF_W1C_MASK) : '0; // R1 R17

    // set wins over a clear in the same cycle
    always_comb begin
        flags_next = (flags_reg & ~clr_vec) | set_vec; // R1 R17
        flags_next[`USBIF_BIT_ERR] = err_sum_reg; // R16
    end

    // event flag register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags_reg <= `USBIF_FLAGS_RST;
        end else begin
            flags_reg <= flags_next;
        end
    end

    // ==========================================================
    // error summary from enabled underlying errors
    wire err_any = |(error_flags & err_en_reg); // R13

    // summary follows the masked errors, no write path
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_sum_reg <= 1'b0;
        end else begin
            err_sum_reg <= err_any; // R13 R16
        end
    end

    // ==========================================================
    // token status fifo advance on clearing a set token flag
    wire tok_cleared = clr_vec[`USBIF_BIT_TOKEN] && flags_reg[`USBIF_BIT_TOKEN];

    // one-cycle advance pulse after the clearing write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fifo_adv_reg <= 1'b0;
        end else begin
            fifo_adv_reg <= tok_cleared; // R11
        end
    end

    // ==========================================================
    // writable configuration registers
    // interrupt enable, same layout as the flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en_reg <= `USBIF_IRQ_EN_RST;
        end else if (wr_ok && sel_irq_en) begin
            irq_en_reg <= pwdata[7:0]; // R8
        end
    end

    // error enable mask for the summary bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_en_reg <= ERR_W'(`USBIF_ERR_EN_RST);
        end else if (wr_ok && sel_err_en) begin
            err_en_reg <= pwdata[ERR_W-1:0];
        end
    end

    // host mode select
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            host_reg <= `USBIF_CTRL_RST;
        end else if (wr_ok && sel_ctrl) begin
            host_reg <= pwdata[`USBIF_BIT_HOST_EN];
        end
    end

    // ==========================================================
    // interrupt output: any enabled flag set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(flags_next & irq_en_reg);
        end
    end

    // ==========================================================
    // read mux, upper bits always zero
    logic [31:0] rd_mux;
    logic [7:0] line_stat;

    // line status word
    always_comb begin
        line_stat = '0;
        line_stat[`USBIF_BIT_LINE_SE0] = line.se0;
        line_stat[`USBIF_BIT_LINE_J] = line.j_state;
        line_stat[`USBIF_BIT_LINE_K] = line.k_state;
        line_stat[`USBIF_BIT_LINE_ATT] = (att_reg == att_attached);
    end

    // register select for reads
    always_comb begin
        rd_mux = '0;
        if (sel_flags) begin
            rd_mux[7:0] = flags_reg; // R2
        end else if (sel_irq_en) begin
            rd_mux[7:0] = irq_en_reg;
        end else if (sel_err_en) begin
            rd_mux[ERR_W-1:0] = err_en_reg;
        end else if (sel_ctrl) begin
            rd_mux[`USBIF_BIT_HOST_EN] = host_reg;
        end else if (sel_line) begin
            rd_mux[7:0] = line_stat;
        end
    end

    // read data captured in the setup cycle, held through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= '0;
        end else if (setup) begin
            prdata_reg <= pwrite ? 32'h0 : rd_mux;
        end
    end

    // ==========================================================
    // outputs
    assign prdata = prdata_reg;
    assign pready = 1'b1; // zero wait states
    assign pslverr = access && !mapped;
    assign host_mode_enable = host_reg;
    assign fifo_advance = fifo_adv_reg;
    assign irq = irq_reg;
endmodule

// ---- core/usbif_line_if.sv ----
`timescale 1ns/100ps
// ==========================================================
// filtered bus line state from the pin synchroniser
interface usbif_line_if;
    logic se0;
    logic j_state;
    logic k_state;
    logic changed;
    modport src (output se0, output j_state, output k_state, output changed);
    modport dst (input se0, input j_state, input k_state, input changed);
endinterface

// ---- core/usbif_pkg.sv ----
package usbif_pkg;
    // ==========================================================
    // types shared by the flag logic
    typedef logic [7:0] usbif_flags_t;
    typedef enum logic [0:0] {
        att_detached,
        att_attached
    } usbif_att_state_t;
endpackage

// ---- core/usbif_regs.svh ----
`ifndef USBIF_REGS_SVH
`define USBIF_REGS_SVH
// ==========================================================
// register offsets (byte addresses)
`define USBIF_OFF_FLAGS 8'h00
`define USBIF_OFF_IRQ_EN 8'h04
`define USBIF_OFF_CLEAR 8'h08
`define USBIF_OFF_ERR_EN 8'h0c
`define USBIF_OFF_CTRL 8'h10
`define USBIF_OFF_LINE 8'h14
// ==========================================================
// event flag bit positions
`define USBIF_BIT_STALL 7
`define USBIF_BIT_ATTACH 6
`define USBIF_BIT_RESUME 5
`define USBIF_BIT_IDLE 4
`define USBIF_BIT_TOKEN 3
`define USBIF_BIT_SOF 2
`define USBIF_BIT_ERR 1
`define USBIF_BIT_RST_DET 0
// control and line status bit positions
`define USBIF_BIT_HOST_EN 0
`define USBIF_BIT_LINE_SE0 0
`define USBIF_BIT_LINE_J 1
`define USBIF_BIT_LINE_K 2
`define USBIF_BIT_LINE_ATT 3
// ==========================================================
// field masks and reset values
`define USBIF_W1C_MASK 8'hfd
`define USBIF_FLAGS_RST 8'h00
`define USBIF_IRQ_EN_RST 8'h00
`define USBIF_ERR_EN_RST 8'h00
`define USBIF_CTRL_RST 1'h0
`define USBIF_LINE_RST 2'h2
// ==========================================================
// timing: times in their own unit, counts derived from the clock
`define USBIF_CLK_PERIOD_NS 8
`define USBIF_T_QUIET_NS 2500
`define USBIF_T_IDLE_MS 3
`define USBIF_CYC_QUIET \
    ((`USBIF_T_QUIET_NS + `USBIF_CLK_PERIOD_NS - 1) / `USBIF_CLK_PERIOD_NS)
`define USBIF_CYC_IDLE \
    ((`USBIF_T_IDLE_MS * 1000000 + `USBIF_CLK_PERIOD_NS - 1) / `USBIF_CLK_PERIOD_NS)
`endif

// ---- core/usbif_sync.sv ----
`timescale 1ns/100ps
`include "usbif_regs.svh"
// ==========================================================
// three-stage pin synchroniser with agreement filter
module usbif_sync
    import usbif_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic dp_pin,
    input wire logic dm_pin,
    usbif_line_if.src line
);
    logic [1:0] ff1_reg;
    logic [1:0] ff2_reg;
    logic [1:0] ff3_reg;
    logic [1:0] stable_reg;
    logic changed_reg;
    wire agree = (ff2_reg == ff3_reg);
    wire moved = agree && (ff3_reg != stable_reg);
    // pin stages; ff1 only feeds ff2
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ff1_reg <= `USBIF_LINE_RST;
            ff2_reg <= `USBIF_LINE_RST;
            ff3_reg <= `USBIF_LINE_RST;
        end else begin
            ff1_reg <= {dp_pin, dm_pin};
            ff2_reg <= ff1_reg;
            ff3_reg <= ff2_reg;
        end
    end
    // accept a new line level once stages two and three agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stable_reg <= `USBIF_LINE_RST;
            changed_reg <= 1'b0;
        end else begin
            changed_reg <= moved;
            if (moved) begin
                stable_reg <= ff3_reg;
            end
        end
    end
    // full-speed decode: j is dp high, k is dm high
    assign line.se0 = (stable_reg == 2'h0);
    assign line.j_state = (stable_reg == 2'h2);
    assign line.k_state = (stable_reg == 2'h1);
    assign line.changed = changed_reg;
endmodule

// ---- dv/usb_interrupt_flag_logic_tb_top.sv ----
`timescale 1ns/100ps
// ==========================================================
// self-checking bench for the event flag block
module usb_interrupt_flag_logic_tb_top import usbif_pkg::*;;
    localparam int QC = 8;
    localparam int IC = 40;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, host, fadv, irq, dp, dm;
    logic [7:0] paddr, eflags, mfl, men, mee, e;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [4:0] evs;
    logic [1:0] lst;
    logic [7:0] dev_bit [4] = '{8'h00, 8'h80, 8'h08, 8'h04};
    int n_errors = 0;
    int n_tests = 0;
    int nfifo = 0;
    int seed;
    usbif_flags #(.QUIET_CYCLES(QC), .IDLE_CYCLES(IC)) i_dut (.pclk, .presetn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
        .dp_pin(dp), .dm_pin(dm), .stall_rx(evs[0]), .stall_tx(evs[1]),
        .token_done(evs[2]), .sof_rx(evs[3]), .sof_threshold(evs[4]),
        .error_flags(eflags), .host_mode_enable(host), .fifo_advance(fadv), .irq);
    usbif_bus_model i_bus (.pclk, .line_state(lst), .dp_pin(dp), .dm_pin(dm));
    // clock
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // count fifo advance pulses
    always @(posedge pclk) begin
        if (fadv === 1'b1) nfifo++;
    end
    task automatic finish_test();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input logic [31:0] s, input logic [31:0] x);
        n_tests++;
        if (s !== x) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, s, x);
        end
    endtask
    // one apb transfer, then an idle cycle
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'hf;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
        apb(1'b0, a, 32'h0);
        check(rd & m, x & m);
    endtask
    // flags without idle bit, and the interrupt line
    task automatic fl();
        rdchk(8'h00, {24'h0, mfl}, 32'hffffffef);
        check({31'h0, irq}, {31'h0, |(mfl & men)});
    endtask
    task automatic clr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
        mfl = mfl & ~(d & 8'hfd);
    endtask
    task automatic ev(input int k);
        evs <= 5'h01 << k;
        @(posedge pclk);
        evs <= 5'h00;
        @(posedge pclk);
    endtask
    task automatic line(input logic [1:0] s);
        lst <= s;
        repeat (QC + 12) @(posedge pclk);
    endtask
    // watchdog
    initial begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        finish_test();
    end
    // main sequence
    initial begin
        seed = 369;
        {presetn, psel, penable, pwrite, paddr, pwdata, pstrb, evs, eflags, lst} = '0;
        mfl = 8'h00;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int a = 0; a < 6; a++) rdchk(8'(a * 4), a == 5 ? 32'h2 : 32'h0, 32'hffffffef);
        apb(1'b0, 8'h18, 32'h0);
        check({31'h0, err}, 32'h1);
        apb(1'b1, 8'h02, 32'hff);
        check({31'h0, err}, 32'h1);
        $display("reset test done");
        men = (8'($random(seed)) & 8'hc1) | 8'h8c;
        apb(1'b1, 8'h04, {24'h0, men});
        for (int k = 0; k < 4; k++) begin
            ev(k);
            mfl = mfl | dev_bit[k];
            fl();
        end
        clr(8'h08, 8'h00);
        fl();
        clr(8'h00, 8'hff);
        fl();
        check(nfifo, 1);
        $display("device event test done");
        for (int i = 0; i < 2; i++) begin
            mee = 8'($random(seed)) | 8'h01;
            e = i == 0 ? (8'($random(seed)) | 8'h01) : ~mee;
            eflags <= e;
            apb(1'b1, 8'h0c, {24'h0, mee});
            mfl[1] = |(e & mee);
            clr(8'h00, 8'h02);
            fl();
        end
        eflags <= 8'h00;
        mfl[1] = 1'b0;
        $display("error summary test done");
        apb(1'b1, 8'h10, 32'h1);
        check({31'h0, host}, 32'h1);
        line(2'h0);
        mfl = mfl | 8'h40;
        fl();
        rdchk(8'h14, 32'ha, 32'hffffffff);
        ev(0);
        ev(1);
        ev(4);
        mfl = mfl | 8'h84;
        fl();
        line(2'h2);
        mfl = mfl | 8'h01;
        fl();
        apb(1'b1, 8'h10, 32'h0);
        line(2'h0);
        clr(8'h00, 8'hff);
        $display("host test done");
        line(2'h1);
        line(2'h0);
        mfl = mfl | 8'h20;
        fl();
        line(2'h2);
        lst <= 2'h0;
        clr(8'h00, 8'h10);
        mfl = mfl | 8'h01;
        fl();
        rdchk(8'h00, {24'h0, mfl}, 32'hffffffff);
        repeat (IC) @(posedge pclk);
        rdchk(8'h00, {24'h0, mfl | 8'h10}, 32'hffffffff);
        $display("line state test done");
        finish_test();
    end
endmodule

// ---- dv/usbif_bus_model.sv ----
`timescale 1ns/100ps
// ==========================================================
// far-side bus agent: line state 0 J, 1 K, 2 SE0
module usbif_bus_model (
    input wire logic pclk,
    input wire logic [1:0] line_state,
    output logic dp_pin,
    output logic dm_pin
);
    // full-speed levels, one clock after the request
    always_ff @(posedge pclk) begin
        dp_pin <= line_state == 2'h0;
        dm_pin <= line_state == 2'h1;
    end
endmodule

// ---- dv/usbif_flags_chk.sv ----
`timescale 1ns/100ps
// ==========================================================
// port-level checks of the event flag block
module usbif_flags_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic stall_rx,
    input wire logic stall_tx,
    input wire logic token_done,
    input wire logic sof_rx,
    input wire logic host_mode_enable,
    input wire logic fifo_advance,
    input wire logic irq
);
    logic [7:0] en_q;
    logic acc;
    logic bad;
    logic clr3;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // completed access, unmapped decode, token clear write
    assign acc = psel && penable && pready;
    assign bad = paddr[1:0] != 2'h0 || paddr > 8'h14;
    assign clr3 = acc && pwrite && pstrb[0] && pwdata[3] && (paddr == 8'h00 || paddr == 8'h08);
    // shadow of the interrupt enable register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q <= 8'h00;
        end else if (acc && pwrite && pstrb[0] && paddr == 8'h04) begin
            en_q <= pwdata[7:0];
        end
    end
    // an enabled event reaches the interrupt line soon
    sequence s_irq_soon;
        ##[1:3] irq;
    endsequence
    a_rsvd_zero: assert property (prdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
    a_err_unmapped: assert property (acc && bad && !pwrite |-> pslverr && prdata == 32'h0)
        else $error("unmapped read not refused");
    a_adv_single: assert property (fifo_advance |=> !fifo_advance)
        else $error("fifo advance longer than one cycle");
    a_adv_cause: assert property (fifo_advance |-> $past(clr3) || $past(clr3, 2))
        else $error("fifo advance without token clear");
    a_token_irq: assert property (token_done && en_q[3] |-> s_irq_soon)
        else $error("token event did not raise irq");
    a_stall_host: assert property (stall_rx && host_mode_enable && en_q[7] |-> s_irq_soon)
        else $error("received stall did not raise irq");
    a_stall_dev: assert property (stall_tx && !host_mode_enable && en_q[7] |-> s_irq_soon)
        else $error("sent stall did not raise irq");
    a_sof_irq: assert property (sof_rx && !host_mode_enable && en_q[2] |-> s_irq_soon)
        else $error("frame start did not raise irq");
    a_irq_masked: assert property (en_q == 8'h00 && $past(en_q) == 8'h00 |-> !irq)
        else $error("irq high with all sources disabled");
endmodule
bind usbif_flags usbif_flags_chk i_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .stall_rx, .stall_tx, .token_done, .sof_rx,
    .host_mode_enable, .fifo_advance, .irq);
